/* core/umcs_cfg.svh */
// register offsets, field positions and reset values of the modem control and status unit
`ifndef UMCS_CFG_SVH
`define UMCS_CFG_SVH

`define UMCS_AW            3
`define UMCS_DW            8

// --------------------------------------------------------------
// register offsets
// --------------------------------------------------------------
`define UMCS_OFS_CTRL      3'h0
`define UMCS_OFS_STAT      3'h1
`define UMCS_OFS_EFR       3'h2
`define UMCS_OFS_IST       3'h3
`define UMCS_OFS_IMSK      3'h4

// --------------------------------------------------------------
// modem_control fields
// --------------------------------------------------------------
`define UMCS_MCR_CLKSEL    7
`define UMCS_MCR_THRESH    6
`define UMCS_MCR_XONANY    5
`define UMCS_MCR_LOOP      4
`define UMCS_MCR_IRQEN     3
`define UMCS_MCR_FRDY      2
`define UMCS_MCR_RTS       1
`define UMCS_MCR_DTR       0
`define UMCS_MCR_HI        7
`define UMCS_MCR_PROT_LO   5
`define UMCS_MCR_OPEN_HI   4

// --------------------------------------------------------------
// enhanced_feature_reg fields
// --------------------------------------------------------------
`define UMCS_EFR_WREN      4
`define UMCS_EFR_AUTORTS   6
`define UMCS_EFR_MASK      8'h50

// --------------------------------------------------------------
// reset values and counts
// --------------------------------------------------------------
`define UMCS_MCR_RST       8'h00
`define UMCS_EFR_RST       8'h00
`define UMCS_PIN_IDLE      4'hF
`define UMCS_NIB_ZERO      4'h0
`define UMCS_NIB_ALL       4'hF
`define UMCS_PRE_LAST      2'h3
`define UMCS_PRE_ONE       2'h1

`endif

/* core/umcs_pkg.sv */
// types of the modem control and status unit
`include "umcs_cfg.svh"

package umcs_pkg;

    // bit order matches the upper nibble of modem_status
    typedef struct packed {
        logic cd;
        logic ri;
        logic dsr;
        logic cts;
    } umcs_modem_t;

    typedef struct packed {
        logic [7:0]  modem_control;
        logic [7:0]  enhanced_feature_reg;
        logic [3:0]  dlt;
        logic [3:0]  ist;
        logic [3:0]  imsk;
        umcs_modem_t s1;
        umcs_modem_t s2;
        umcs_modem_t prev;
        logic        ri_lvl;
        logic [1:0]  pre;
        logic [7:0]  rdata;
        logic        rts_n;
        logic        dtr_n;
        logic        op;
        logic        irq;
        logic        irq_oe;
        logic        ser_out;
        logic        rx;
        logic        baud_en;
        logic        auto_rts;
    } umcs_state_t;

endpackage

/* core/umcs_top.sv */
// modem control and status unit of one uart channel
//
// Operation
// - control bit 7 set divides baud clock input by four, cleared passes it.
// - control bit 6 set opens threshold and trigger register access.
// - control bit 5 enables resume-on-any-character flow control.
// - control bits 7..5 change only while feature write enable is set.
// - control bit 4 loops serial transmit output back to receive input.
// - in loopback low control nibble feeds upper status nibble.
// - control bit 3 cleared floats interrupt outputs, general output high.
// - control bit 3 set drives interrupt outputs, general output low.
// - control bit 2 enables the fifo-ready status register.
// - without auto rts, control bit 1 set drives rts pin low.
// - with auto rts enabled, flow control drives the rts pin.
// - control bit 0 set drives terminal-ready pin low.
// - normal mode status 7..4 are inverted cd, ri, dsr, cts pins.
// - loopback status 7,6,5,4 equal control 3,2,0,1.
// - status 3,1,0 set on any change of cd, dsr, cts sources.
// - status 2 sets on ring pin low-to-high, or control bit 2 rise.
// - reading status clears the four change bits.
// - modem pins active low, their register images active high.
`timescale 1ns/1ps
`default_nettype none
`include "umcs_cfg.svh"

module umcs_top
    import umcs_pkg::*;
(
    input  wire logic                 REF_CLK,
    input  wire logic                 RST_N,
    input  wire logic [`UMCS_AW-1:0]  ADDR,
    input  wire logic [`UMCS_DW-1:0]  WDATA,
    input  wire logic                 WR,
    input  wire logic                 RD,
    output var  logic [`UMCS_DW-1:0]  RDATA,
    input  wire logic                 CLEAR_TO_SEND_PIN_N,
    input  wire logic                 SET_READY_PIN_N,
    input  wire logic                 CARRIER_DETECT_PIN_N,
    input  wire logic                 RING_INDICATOR_PIN_N,
    output var  logic                 REQUEST_TO_SEND_PIN_N,
    output var  logic                 TERMINAL_READY_PIN_N,
    output var  logic                 GENERAL_OUTPUT_PIN,
    output var  logic                 IRQ_OUT_A,
    output var  logic                 IRQ_OUT_A_OE,
    output var  logic                 IRQ_OUT_B,
    output var  logic                 IRQ_OUT_B_OE,
    output var  logic                 IRQ,
    input  wire logic                 AUTO_RTS_REQ_N,
    output var  logic                 AUTO_RTS_EN,
    input  wire logic                 TX_SERIAL,
    output var  logic                 RX_SERIAL,
    input  wire logic                 SERIAL_IN_PIN,
    output var  logic                 SERIAL_OUT_PIN,
    output var  logic                 BAUD_CLK_EN,
    output var  logic                 THRESH_ACCESS_EN,
    output var  logic                 XON_ANY_EN,
    output var  logic                 FIFO_RDY_EN
);

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    // set wins over clear so an event in the clearing cycle survives
    function automatic logic [3:0] sticky(
        input logic [3:0] cur,
        input logic [3:0] clr,
        input logic [3:0] set
    );
        sticky = (cur & ~clr) | set;
    endfunction

    function automatic logic hit(
        input logic [`UMCS_AW-1:0] a,
        input logic [`UMCS_AW-1:0] ofs
    );
        hit = (a == ofs);
    endfunction

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    umcs_state_t state_r;
    umcs_state_t state_nxt;

    umcs_modem_t img;
    umcs_modem_t src;
    logic [3:0]  chg;
    logic [3:0]  evt;
    logic        loop;
    logic        lvl;
    logic        rd_stat;
    logic [3:0]  ist_clr;

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        loop      = state_r.modem_control[`UMCS_MCR_LOOP];

        // pins are active low, images active high
        img = umcs_modem_t'(~state_r.s2);

        if (loop) begin
            // loopback takes the control nibble as sources
            src.cd  = state_r.modem_control[`UMCS_MCR_IRQEN];
            src.ri  = state_r.modem_control[`UMCS_MCR_FRDY];
            src.dsr = state_r.modem_control[`UMCS_MCR_DTR];
            src.cts = state_r.modem_control[`UMCS_MCR_RTS];
            lvl     = state_r.modem_control[`UMCS_MCR_FRDY];
        end else begin
            src = img;
            lvl = state_r.s2.ri;
        end

        // change detection on synchronised sources only
        chg    = src ^ state_r.prev;
        evt    = chg;
        evt[2] = lvl & ~state_r.ri_lvl;
        // evt[3], evt[1], evt[0] are any change of cd, dsr, cts

        state_nxt.s1.cd  = CARRIER_DETECT_PIN_N;
        state_nxt.s1.ri  = RING_INDICATOR_PIN_N;
        state_nxt.s1.dsr = SET_READY_PIN_N;
        state_nxt.s1.cts = CLEAR_TO_SEND_PIN_N;
        state_nxt.s2     = state_r.s1;
        state_nxt.prev   = src;
        state_nxt.ri_lvl = lvl;

        rd_stat = RD && hit(ADDR, `UMCS_OFS_STAT);
        ist_clr = `UMCS_NIB_ZERO;
        if (WR && hit(ADDR, `UMCS_OFS_IST)) begin
            ist_clr = WDATA[3:0];
        end

        // read clears the change bits
        state_nxt.dlt = sticky(state_r.dlt, rd_stat ? `UMCS_NIB_ALL : `UMCS_NIB_ZERO, evt);
        state_nxt.ist = sticky(state_r.ist, ist_clr, evt);

        // ----------------------------------------------------------
        // register writes
        // ----------------------------------------------------------
        if (WR) begin
            case (ADDR)
                `UMCS_OFS_CTRL: begin
                    state_nxt.modem_control[`UMCS_MCR_OPEN_HI:0] = WDATA[`UMCS_MCR_OPEN_HI:0];
                    if (state_r.enhanced_feature_reg[`UMCS_EFR_WREN]) begin
                        state_nxt.modem_control[`UMCS_MCR_HI:`UMCS_MCR_PROT_LO] =
                            WDATA[`UMCS_MCR_HI:`UMCS_MCR_PROT_LO];
                    end
                end
                `UMCS_OFS_EFR: begin
                    state_nxt.enhanced_feature_reg = WDATA & `UMCS_EFR_MASK;
                end
                `UMCS_OFS_IMSK: begin
                    state_nxt.imsk = WDATA[3:0];
                end
                default: begin
                end
            endcase
        end

        // ----------------------------------------------------------
        // register reads, answer one cycle later
        // ----------------------------------------------------------
        state_nxt.rdata = 8'h00;
        if (RD) begin
            case (ADDR)
                `UMCS_OFS_CTRL: state_nxt.rdata = state_r.modem_control;
                `UMCS_OFS_STAT: state_nxt.rdata = {src, state_r.dlt};
                `UMCS_OFS_EFR:  state_nxt.rdata = state_r.enhanced_feature_reg;
                `UMCS_OFS_IST:  state_nxt.rdata = {4'h0, state_r.ist};
                `UMCS_OFS_IMSK: state_nxt.rdata = {4'h0, state_r.imsk};
                default:        state_nxt.rdata = 8'h00;
            endcase
        end

        // ----------------------------------------------------------
        // pins
        // ----------------------------------------------------------
        state_nxt.auto_rts = state_r.enhanced_feature_reg[`UMCS_EFR_AUTORTS];
        if (state_r.enhanced_feature_reg[`UMCS_EFR_AUTORTS]) begin
            state_nxt.rts_n = AUTO_RTS_REQ_N;
        end else begin
            state_nxt.rts_n = ~state_r.modem_control[`UMCS_MCR_RTS];
        end
        state_nxt.dtr_n = ~state_r.modem_control[`UMCS_MCR_DTR];

        // enable off floats the irq pins, op high; on drives them, op low
        state_nxt.irq_oe = state_r.modem_control[`UMCS_MCR_IRQEN];
        state_nxt.op     = ~state_r.modem_control[`UMCS_MCR_IRQEN];
        state_nxt.irq    = |(state_r.ist & state_r.imsk);

        // line held at mark in loopback so the far end sees idle
        if (loop) begin
            state_nxt.ser_out = 1'b1;
            state_nxt.rx      = TX_SERIAL;
        end else begin
            state_nxt.ser_out = TX_SERIAL;
            state_nxt.rx      = SERIAL_IN_PIN;
        end

        // prescaler as an enable pulse, one cycle in four when set
        if (state_r.modem_control[`UMCS_MCR_CLKSEL]) begin
            state_nxt.pre     = state_r.pre + `UMCS_PRE_ONE;
            state_nxt.baud_en = (state_r.pre == `UMCS_PRE_LAST);
        end else begin
            state_nxt.pre     = 2'h0;
            state_nxt.baud_en = 1'b1;
        end
    end

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r         <= '0;
            state_r.modem_control     <= `UMCS_MCR_RST;
            state_r.enhanced_feature_reg     <= `UMCS_EFR_RST;
            state_r.s1      <= `UMCS_PIN_IDLE;
            state_r.s2      <= `UMCS_PIN_IDLE;
            state_r.ri_lvl  <= 1'b1;
            state_r.rts_n   <= 1'b1;
            state_r.dtr_n   <= 1'b1;
            state_r.op      <= 1'b1;
            state_r.ser_out <= 1'b1;
            state_r.rx      <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign RDATA                 = state_r.rdata;
    assign REQUEST_TO_SEND_PIN_N = state_r.rts_n;
    assign TERMINAL_READY_PIN_N  = state_r.dtr_n;
    assign GENERAL_OUTPUT_PIN    = state_r.op;
    assign IRQ_OUT_A             = state_r.irq;
    assign IRQ_OUT_A_OE          = state_r.irq_oe;
    assign IRQ_OUT_B             = state_r.irq;
    assign IRQ_OUT_B_OE          = state_r.irq_oe;
    assign IRQ                   = state_r.irq;
    assign AUTO_RTS_EN           = state_r.auto_rts;
    assign RX_SERIAL             = state_r.rx;
    assign SERIAL_OUT_PIN        = state_r.ser_out;
    assign BAUD_CLK_EN           = state_r.baud_en;
    assign THRESH_ACCESS_EN      = state_r.modem_control[`UMCS_MCR_THRESH];
    assign XON_ANY_EN            = state_r.modem_control[`UMCS_MCR_XONANY];
    assign FIFO_RDY_EN           = state_r.modem_control[`UMCS_MCR_FRDY];

endmodule // umcs_top

`default_nettype wire

/* testbench/umcs_assertions.sv */
// port checker of the modem control and status unit
`timescale 1ns/1ps
`default_nettype none
`include "umcs_cfg.svh"

module umcs_assertions (
    input wire logic                REF_CLK,
    input wire logic                RST_N,
    input wire logic [`UMCS_AW-1:0] ADDR,
    input wire logic [`UMCS_DW-1:0] WDATA,
    input wire logic                WR,
    input wire logic                RD,
    input wire logic [`UMCS_DW-1:0] RDATA,
    input wire logic                REQUEST_TO_SEND_PIN_N,
    input wire logic                TERMINAL_READY_PIN_N,
    input wire logic                GENERAL_OUTPUT_PIN,
    input wire logic                IRQ_OUT_A,
    input wire logic                IRQ_OUT_A_OE,
    input wire logic                IRQ_OUT_B,
    input wire logic                IRQ_OUT_B_OE,
    input wire logic                IRQ,
    input wire logic                AUTO_RTS_REQ_N,
    input wire logic                AUTO_RTS_EN,
    input wire logic                TX_SERIAL,
    input wire logic                RX_SERIAL,
    input wire logic                SERIAL_OUT_PIN,
    input wire logic                BAUD_CLK_EN
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // ------------------------------------------------
    // control write and its two-cycle landing on pins
    // ------------------------------------------------
    sequence s_ctrl_wr;
        WR && ADDR == `UMCS_OFS_CTRL;
    endsequence
    sequence s_settle;
        s_ctrl_wr ##2 1'b1;
    endsequence
    property p_op_oe;
        GENERAL_OUTPUT_PIN == !IRQ_OUT_A_OE;
    endproperty
    property p_irq_pair;
        IRQ_OUT_A_OE == IRQ_OUT_B_OE && IRQ_OUT_A == IRQ && IRQ_OUT_B == IRQ;
    endproperty
    property p_ctrl_pins;
        s_settle |-> GENERAL_OUTPUT_PIN == !$past(WDATA[3], 2)
            && TERMINAL_READY_PIN_N == !$past(WDATA[0], 2);
    endproperty
    property p_rts;
        s_ctrl_wr ##0 !AUTO_RTS_EN ##2 !AUTO_RTS_EN
            |-> REQUEST_TO_SEND_PIN_N == !$past(WDATA[1], 2);
    endproperty
    property p_auto_rts;
        AUTO_RTS_EN && $past(AUTO_RTS_EN) && $stable(AUTO_RTS_REQ_N)
            |-> REQUEST_TO_SEND_PIN_N == AUTO_RTS_REQ_N;
    endproperty
    property p_loop;
        s_ctrl_wr ##0 WDATA[4] |-> ##2 (SERIAL_OUT_PIN && RX_SERIAL == $past(TX_SERIAL));
    endproperty
    // divide-by-four still leaves at most three idle cycles
    property p_baud;
        !BAUD_CLK_EN [*3] |=> BAUD_CLK_EN;
    endproperty
    property p_rd_idle;
        !$past(RD) |-> RDATA == 8'h00;
    endproperty
    property p_unmapped;
        RD && ADDR > `UMCS_OFS_IMSK |=> RDATA == 8'h00;
    endproperty
    a_op_oe: assert property (p_op_oe) else $error("op pin not inverse of enable");
    a_irq_pair: assert property (p_irq_pair) else $error("irq outputs disagree");
    a_ctrl_pins: assert property (p_ctrl_pins) else $error("ctrl pins wrong");
    a_rts: assert property (p_rts) else $error("rts not from ctrl bit");
    a_auto_rts: assert property (p_auto_rts) else $error("rts not from flow ctrl");
    a_loop: assert property (p_loop) else $error("loopback path wrong");
    a_baud: assert property (p_baud) else $error("baud enable gap too long");
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // umcs_assertions

bind umcs_top umcs_assertions umcs_assertions_inst (.*);
`default_nettype wire

/* testbench/umcs_modem_model.sv */
// modem side model: drives the four status lines, prompt or one cycle late
`timescale 1ns/1ps
`default_nettype none

module umcs_modem_model
    import umcs_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        slow,
    input  wire umcs_modem_t want,
    output var  umcs_modem_t pin_n
);
    umcs_modem_t dly_r;
    always_ff @(posedge ref_clk) dly_r <= want;
    assign pin_n = ~(slow ? dly_r : want); // lines are active low on the wire
endmodule // umcs_modem_model
`default_nettype wire

/* testbench/uart_modem_control_status_tb.sv */
// self-checking bench of the modem control and status unit
`timescale 1ns/1ps
`default_nettype none
`include "umcs_cfg.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module uart_modem_control_status_tb;
    typedef struct { logic [7:0] enhanced_feature_reg, wd, ctl; } umcs_row_t;
    logic REF_CLK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0, AREQ_N = 1'b1, TXS = 1'b1;
    logic slow = 1'b0;
    logic [2:0] ADDR = 3'h0;
    logic [7:0] WDATA = 8'h00, RDATA;
    logic RTS_N, DTR_N, OP, IA, IAOE, IB, IBOE, IRQ, ARE, RXS, SO, BAUD, THR, XON, FRDY;
    umcs_pkg::umcs_modem_t want = '0, pins;
    int err_count = 0, n_compared = 0, cyc = 0, cnt;
    // protected bits 7..5 only move when the feature write enable is set
    umcs_row_t rows[5] = '{'{8'h00, 8'h0F, 8'h0F}, '{8'h00, 8'hE0, 8'h00},
        '{8'h10, 8'hEA, 8'hEA}, '{8'h00, 8'h05, 8'hE5}, '{8'h10, 8'h00, 8'h00}};

    umcs_top umcs_top_inst (.REF_CLK(REF_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .CLEAR_TO_SEND_PIN_N(pins.cts),
        .SET_READY_PIN_N(pins.dsr), .CARRIER_DETECT_PIN_N(pins.cd),
        .RING_INDICATOR_PIN_N(pins.ri), .REQUEST_TO_SEND_PIN_N(RTS_N),
        .TERMINAL_READY_PIN_N(DTR_N), .GENERAL_OUTPUT_PIN(OP), .IRQ_OUT_A(IA),
        .IRQ_OUT_A_OE(IAOE), .IRQ_OUT_B(IB), .IRQ_OUT_B_OE(IBOE), .IRQ(IRQ),
        .AUTO_RTS_REQ_N(AREQ_N), .AUTO_RTS_EN(ARE), .TX_SERIAL(TXS), .RX_SERIAL(RXS),
        .SERIAL_IN_PIN(~TXS), .SERIAL_OUT_PIN(SO), .BAUD_CLK_EN(BAUD),
        .THRESH_ACCESS_EN(THR), .XON_ANY_EN(XON), .FIFO_RDY_EN(FRDY));
    umcs_modem_model umcs_modem_model_inst (.ref_clk(REF_CLK), .slow(slow), .want(want),
        .pin_n(pins));

    always #25 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK) begin
        TXS <= ~TXS;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            end_of_test();
        end
    end
    // ------------------------------------------------
    // bus tasks
    // ------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        ADDR <= a; WDATA <= d; WR <= 1'b1;
        @(posedge REF_CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge REF_CLK);
        ADDR <= a; RD <= 1'b1;
        @(posedge REF_CLK);
        RD <= 1'b0;
        #1 `CHK(RDATA, e)
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge REF_CLK);
        #1;
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        idle(5);
        `CHK({RTS_N, DTR_N, OP, IAOE}, 4'hE)
        RST_N <= 1'b1;
        rd(`UMCS_OFS_STAT, 8'h00);
        foreach (rows[i]) begin
            wr(`UMCS_OFS_EFR, rows[i].enhanced_feature_reg);
            wr(`UMCS_OFS_CTRL, rows[i].wd);
            idle(2);
            `CHK({RTS_N, DTR_N, OP, IAOE}, {~rows[i].ctl[1:0], ~rows[i].ctl[3], rows[i].ctl[3]})
            `CHK({THR, XON, FRDY}, {rows[i].ctl[6:5], rows[i].ctl[2]})
            rd(`UMCS_OFS_CTRL, rows[i].ctl);
            cnt = 0;
            repeat (8) begin
                idle(1);
                cnt += BAUD;
            end
            `CHK(cnt, rows[i].ctl[7] ? 2 : 8)
        end
        // ------------------------------------------------
        // modem lines, change flags, interrupts
        // ------------------------------------------------
        want.cd <= 1'b1;
        idle(5);
        rd(`UMCS_OFS_STAT, 8'h88);
        rd(`UMCS_OFS_STAT, 8'h80);
        want.ri <= 1'b1;
        idle(5);
        rd(`UMCS_OFS_STAT, 8'hC0);
        want <= 4'b1011;
        slow <= 1'b1;
        idle(6);
        rd(`UMCS_OFS_STAT, 8'hB7);
        `CHK(IRQ, 1'b0)
        rd(`UMCS_OFS_IST, 8'h0F);
        wr(`UMCS_OFS_IMSK, 8'h01);
        idle(2);
        `CHK({IRQ, IA}, 2'b11)
        wr(`UMCS_OFS_IST, 8'h01);
        idle(2);
        `CHK(IRQ, 1'b0)
        rd(`UMCS_OFS_IST, 8'h0E);
        want.cts <= 1'b0;
        idle(6);
        `CHK(IRQ, 1'b1)
        wr(`UMCS_OFS_IST, 8'h0F);
        wr(`UMCS_OFS_IMSK, 8'h00);
        rd(`UMCS_OFS_STAT, 8'hA1);
        // ------------------------------------------------
        // flow-control rts, loopback, odd addresses, reset
        // ------------------------------------------------
        wr(`UMCS_OFS_EFR, 8'h40);
        AREQ_N <= 1'b0;
        idle(3);
        `CHK(RTS_N, 1'b0)
        wr(`UMCS_OFS_EFR, 8'h00);
        idle(2);
        `CHK(RTS_N, 1'b1)
        `CHK({SO, RXS}, {~TXS, TXS})
        wr(`UMCS_OFS_CTRL, 8'h1D);
        idle(3);
        // entering loopback compares control bit 2 with the old pin level, so no ring flag
        rd(`UMCS_OFS_STAT, 8'hE0);
        `CHK({SO, RXS}, {1'b1, ~TXS})
        wr(`UMCS_OFS_CTRL, 8'h1A);
        idle(3);
        rd(`UMCS_OFS_STAT, 8'h93);
        wr(`UMCS_OFS_CTRL, 8'h1E);
        idle(3);
        rd(`UMCS_OFS_STAT, 8'hD4);
        wr(3'h6, 8'hFF);
        rd(3'h5, 8'h00);
        rd(`UMCS_OFS_CTRL, 8'h1E);
        RST_N <= 1'b0;
        idle(2);
        `CHK({RTS_N, DTR_N, OP, IAOE}, 4'hE)
        RST_N <= 1'b1;
        rd(`UMCS_OFS_CTRL, 8'h00);
        end_of_test();
    end
endmodule // uart_modem_control_status_tb
`default_nettype wire
